// File: hdl/mcs_pkg.sv
// constants shared by the multichip sync device end and its host end
// What this block does
// - two modes: data rate, data rate over eight
// - data rate mode uses no fifo elasticity
// - multiplier clocking forces data rate mode only
// - multiplier mode: reference doubles as sync
// - 0xC0 written first selects data rate
// - status bit6 locked, bit7 lost
// - host checks locked high, lost low first
// - word-align held two words resets fifo
// - host runs sequence on each device separately
// - multiplier reference: data rate over 2^N as well
// - direct clocking: data rate over 2^N
// - host prefers fifo rate when N>=3
// - direct clocking syncs from separate reference
// - synced: same phase, aligned fifo reads
// - inputs sampled on sample clock rising edge
// - 0x80 selects fifo rate, then poll, align
// - lost latches until register overwritten
package mcs_pkg;
  localparam logic [7:0] SYNC_CTRL_OFS = 8'h10;
  localparam logic [7:0] PHASE_REQ_OFS = 8'h11;
  localparam logic [7:0] SYNC_STAT_OFS = 8'h12;
  localparam logic [7:0] PHASE_RB_OFS = 8'h13;
  localparam logic [7:0] CTRL_DATA_RATE = 8'hC0;
  localparam logic [7:0] CTRL_FIFO_RATE = 8'h80;
  localparam logic [7:0] SYNC_CTRL_RST = 8'h00;
  localparam logic [5:0] PHASE_REQ_RST = 6'h00;
  localparam int CTL_EN_BIT = 7;
  localparam int CTL_DR_BIT = 6;
  localparam int STAT_LOCK_BIT = 6;
  localparam int STAT_LOST_BIT = 7;
  localparam int FIFO_DEPTH = 8;
  localparam int FRAME_WORDS = 2;
  localparam int MAX_PLL_N = 3;
  localparam int FIFO_PREF_N = 3;
  localparam int DATA_DIV = 2;
  localparam int DATA_W = 16;
  // host controller apb map
  localparam logic [7:0] HOST_CTRL_OFS = 8'h00;
  localparam logic [7:0] HOST_STAT_OFS = 8'h04;
  localparam logic [7:0] HOST_IRQ_STAT_OFS = 8'h08;
  localparam logic [7:0] HOST_IRQ_MASK_OFS = 8'h0C;
  localparam int HC_START_BIT = 0;
  localparam int HC_FIFO_BIT = 1;
  localparam int HC_N_LSB = 2;
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_LOST_BIT = 1;
  localparam logic [1:0] IRQ_RST = 2'h0;
  typedef enum logic [2:0] {
    HS_IDLE, HS_WR, HS_WR_WAIT, HS_RD, HS_RD_WAIT, HS_FRAME
  } mcs_host_state_e;
endpackage

// File: hdl/mcs_link_if.sv
// link between the data source/host end and the converter sync end
`timescale 1ns/1ps
interface mcs_link_if;
  import mcs_pkg::*;
  logic sync_reference_clock;
  logic input_data_clock;
  logic [DATA_W-1:0] data;
  logic word_align;
  logic reg_req;
  logic reg_we;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic reg_ack;
  modport dev (
    input sync_reference_clock, input input_data_clock, input data, input word_align,
    input reg_req, input reg_we, input reg_addr, input reg_wdata,
    output reg_rdata, output reg_ack
  );
  modport host (
    output sync_reference_clock, output input_data_clock, output data, output word_align,
    output reg_req, output reg_we, output reg_addr, output reg_wdata,
    input reg_rdata, input reg_ack
  );
endinterface

// File: hdl/mcs_sync_dev.sv
// converter end: clock phase alignment, sync registers and 8-deep input fifo
`timescale 1ns/1ps
module mcs_sync_dev #(
  parameter int DIV = mcs_pkg::DATA_DIV
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  mcs_link_if.dev link,
  input wire logic pll_mode_i,
  output logic [mcs_pkg::DATA_W-1:0] dac_data_o,
  output logic [5:0] clk_phase_o,
  output logic locked_o
);
  import mcs_pkg::*;

  logic [7:0] sync_ctrl_r;
  logic [5:0] phase_req_r;
  logic locked_r;
  logic lost_r;
  logic [5:0] phase_r;
  logic [7:0] avg_cnt_r;
  logic ref_q_r;
  logic dci_q_r;
  logic frame_q_r;
  logic [DATA_W-1:0] mem_r [FIFO_DEPTH];
  logic [2:0] wr_ptr_r;
  logic [2:0] rd_ptr_r;
  logic [7:0] rdata_r;
  logic ack_r;
  logic data_rate;
  logic [5:0] period_mask;
  logic ref_rise;
  logic on_boundary;
  logic mismatch;
  logic [7:0] avg_need;
  logic wr_stat;

  // multiplier clocking can only use data rate mode
  assign data_rate = sync_ctrl_r[CTL_DR_BIT] | pll_mode_i;
  // slowest aligned clock: one data word, or eight of them
  assign period_mask = data_rate ? 6'(DIV - 1) : 6'(DIV * FIFO_DEPTH - 1);
  // all link inputs are taken on the rising sample clock edge
  assign ref_rise = link.sync_reference_clock & ~ref_q_r;
  // one reference pin serves either clocking scheme
  assign on_boundary = (phase_r & period_mask) == 6'h00;
  // a reference edge off a period boundary means phase drift
  assign mismatch = ref_rise & ~on_boundary & sync_ctrl_r[CTL_EN_BIT];
  // averaging field picks 1..128 matching edges before lock
  assign avg_need = 8'h01 << sync_ctrl_r[2:0];
  assign wr_stat = link.reg_req & link.reg_we & (link.reg_addr == SYNC_STAT_OFS);

  // edge history of the link strobes
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      ref_q_r <= 1'b0;
      dci_q_r <= 1'b0;
      frame_q_r <= 1'b0;
    end else begin
      ref_q_r <= link.sync_reference_clock;
      dci_q_r <= link.input_data_clock;
      frame_q_r <= link.word_align;
    end
  end

  // clock generation phase: free run, restart at request on drift
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      phase_r <= 6'h00;
    end else if (mismatch) begin
      // this edge counts as state request, so next is request+1
      phase_r <= phase_req_r + 6'h01;
    end else begin
      phase_r <= phase_r + 6'h01;
    end
  end

  // lock after enough consecutive matching reference edges
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      avg_cnt_r <= 8'h00;
      locked_r <= 1'b0;
    end else if (!sync_ctrl_r[CTL_EN_BIT] || mismatch) begin
      avg_cnt_r <= 8'h00;
      locked_r <= 1'b0;
    end else if (ref_rise && !locked_r) begin
      if (avg_cnt_r + 8'h01 >= avg_need) begin
        locked_r <= 1'b1;
      end
      avg_cnt_r <= avg_cnt_r + 8'h01;
    end
  end

  // lost latches on drift after lock; overwriting the register loads it from bit 7 of the written byte
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      lost_r <= 1'b0;
    end else if (mismatch && locked_r) begin
      lost_r <= 1'b1; // set wins over a same-cycle overwrite
    end else if (wr_stat) begin
      lost_r <= link.reg_wdata[STAT_LOST_BIT];
    end
  end

  // control registers written over the register port
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      sync_ctrl_r <= SYNC_CTRL_RST;
      phase_req_r <= PHASE_REQ_RST;
    end else if (link.reg_req && link.reg_we) begin
      if (link.reg_addr == SYNC_CTRL_OFS) begin
        sync_ctrl_r <= link.reg_wdata; // 0xC0 data rate, 0x80 fifo rate
      end
      if (link.reg_addr == PHASE_REQ_OFS) begin
        phase_req_r <= link.reg_wdata[5:0];
      end
    end
  end

  // read data and one-cycle acknowledge; unmapped reads return zero
  // read data is captured only on a request so it stands until the next one
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_r <= 8'h00;
      ack_r <= 1'b0;
    end else begin
      ack_r <= link.reg_req;
      if (link.reg_req) begin
        case (link.reg_addr)
          SYNC_CTRL_OFS: rdata_r <= sync_ctrl_r;
          PHASE_REQ_OFS: rdata_r <= {2'b00, phase_req_r};
          SYNC_STAT_OFS: rdata_r <= {lost_r, locked_r, 6'h00};
          PHASE_RB_OFS: rdata_r <= {phase_r, 2'b00};
          default: rdata_r <= 8'h00;
        endcase
      end
    end
  end

  // fifo write side, driven by the data clock rising edge
  always_ff @(posedge sys_clk_i) begin
    if (link.input_data_clock && !dci_q_r) begin
      mem_r[wr_ptr_r] <= link.data;
    end
  end

  // pointers: word-align rise realigns both so all parts read together
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      wr_ptr_r <= 3'h0;
      rd_ptr_r <= 3'h0;
    end else if (link.word_align && !frame_q_r) begin
      wr_ptr_r <= 3'h0;
      // data rate keeps the read one word behind: no slack to absorb skew
      rd_ptr_r <= data_rate ? 3'(FIFO_DEPTH - 1) : 3'(FIFO_DEPTH / 2);
    end else begin
      if (link.input_data_clock && !dci_q_r) begin
        wr_ptr_r <= wr_ptr_r + 3'h1;
      end
      if ((phase_r & 6'(DIV - 1)) == 6'h00) begin
        rd_ptr_r <= rd_ptr_r + 3'h1; // reads keyed to phase
      end
    end
  end

  // fifo read at each data-word phase boundary
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      dac_data_o <= '0;
    end else if ((phase_r & 6'(DIV - 1)) == 6'h00) begin
      dac_data_o <= mem_r[rd_ptr_r];
    end
  end

  assign link.reg_rdata = rdata_r;
  assign link.reg_ack = ack_r;
  assign clk_phase_o = phase_r;
  assign locked_o = locked_r;
endmodule

// File: hdl/mcs_sync_host.sv
// host end: apb-driven sync sequencer plus data, data clock and reference source
`timescale 1ns/1ps
module mcs_sync_host #(
  parameter int DIV = mcs_pkg::DATA_DIV,
  parameter int DIV_LOG = 1
) (
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [mcs_pkg::DATA_W-1:0] tx_data_i,
  output logic irq_o,
  mcs_link_if.host link
);
  import mcs_pkg::*;

  mcs_host_state_e state_r;
  logic fifo_sel_r;
  logic [2:0] ref_n_r;
  logic [1:0] irq_stat_r;
  logic [1:0] irq_mask_r;
  logic [7:0] last_stat_r;
  logic [9:0] t_r;
  logic [9:0] t_nxt;
  logic [7:0] frame_cnt_r;
  logic done_ev;
  logic lost_ev;
  logic apb_wr;
  logic start;
  logic fifo_mode;

  assign apb_wr = psel & penable & pwrite;
  assign start = apb_wr && paddr == HOST_CTRL_OFS && pwdata[HC_START_BIT];
  // fifo rate asked for, or reference divider too deep for data rate
  assign fifo_mode = fifo_sel_r | (ref_n_r >= 3'(FIFO_PREF_N));
  assign t_nxt = t_r + 10'h001;
  assign done_ev = state_r == HS_FRAME && frame_cnt_r == 8'h01;
  assign lost_ev = state_r == HS_RD_WAIT && link.reg_ack && link.reg_rdata[STAT_LOST_BIT];

  // apb: zero wait, slave error on unmapped offsets
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~(paddr == HOST_CTRL_OFS | paddr == HOST_STAT_OFS |
    paddr == HOST_IRQ_STAT_OFS | paddr == HOST_IRQ_MASK_OFS);
  always_comb begin
    case (paddr)
      HOST_CTRL_OFS: prdata = {27'h0, ref_n_r, fifo_sel_r, 1'b0};
      HOST_STAT_OFS: prdata = {16'h0, last_stat_r, 7'h0, state_r != HS_IDLE};
      HOST_IRQ_STAT_OFS: prdata = {30'h0, irq_stat_r};
      HOST_IRQ_MASK_OFS: prdata = {30'h0, irq_mask_r};
      default: prdata = 32'h0;
    endcase
  end

  // configuration and mask registers
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      fifo_sel_r <= 1'b0;
      ref_n_r <= 3'h0;
      irq_mask_r <= IRQ_RST;
    end else if (apb_wr) begin
      if (paddr == HOST_CTRL_OFS) begin
        fifo_sel_r <= pwdata[HC_FIFO_BIT];
        ref_n_r <= pwdata[HC_N_LSB +: 3];
      end
      if (paddr == HOST_IRQ_MASK_OFS) begin
        irq_mask_r <= pwdata[1:0];
      end
    end
  end

  // sticky events, write one to clear; a new event beats the clear
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      irq_stat_r <= IRQ_RST;
    end else begin
      irq_stat_r <= (irq_stat_r & ~((apb_wr && paddr == HOST_IRQ_STAT_OFS) ? pwdata[1:0] : 2'b00))
        | {lost_ev, done_ev};
    end
  end
  assign irq_o = |(irq_stat_r & irq_mask_r);

  // sequence: configure, poll status, align fifo; one device per host end
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_r <= HS_IDLE;
      link.reg_req <= 1'b0;
      link.reg_we <= 1'b0;
      link.reg_addr <= 8'h00;
      link.reg_wdata <= 8'h00;
      last_stat_r <= 8'h00;
      frame_cnt_r <= 8'h00;
      link.word_align <= 1'b0;
    end else begin
      link.reg_req <= 1'b0;
      case (state_r)
        HS_IDLE: if (start) begin
          state_r <= HS_WR;
        end
        HS_WR: begin
          link.reg_req <= 1'b1;
          link.reg_we <= 1'b1;
          link.reg_addr <= SYNC_CTRL_OFS;
          link.reg_wdata <= fifo_mode ? CTRL_FIFO_RATE : CTRL_DATA_RATE;
          state_r <= HS_WR_WAIT;
        end
        HS_WR_WAIT: if (link.reg_ack) begin
          state_r <= HS_RD;
        end
        HS_RD: begin
          link.reg_req <= 1'b1;
          link.reg_we <= 1'b0;
          link.reg_addr <= SYNC_STAT_OFS;
          state_r <= HS_RD_WAIT;
        end
        HS_RD_WAIT: if (link.reg_ack) begin
          last_stat_r <= link.reg_rdata;
          // fifo reset only once locked and not lost
          if (link.reg_rdata[STAT_LOCK_BIT] && !link.reg_rdata[STAT_LOST_BIT]) begin
            state_r <= HS_FRAME;
            link.word_align <= 1'b1;
            // two whole words plus one of margin
            frame_cnt_r <= 8'((FRAME_WORDS + 1) * DIV);
          end else begin
            state_r <= HS_RD;
          end
        end
        HS_FRAME: begin
          frame_cnt_r <= frame_cnt_r - 8'h01;
          if (frame_cnt_r == 8'h01) begin
            link.word_align <= 1'b0;
            state_r <= HS_IDLE;
          end
        end
        default: state_r <= HS_IDLE;
      endcase
    end
  end

  // data clock, data and reference from one counter, edges on word boundaries
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      t_r <= 10'h000;
      link.input_data_clock <= 1'b0;
      link.sync_reference_clock <= 1'b0;
      link.data <= '0;
    end else begin
      t_r <= t_nxt;
      link.input_data_clock <= ~t_nxt[DIV_LOG-1];
      // reference at data rate over 2^N; only N up to three is legal with the multiplier
      link.sync_reference_clock <= ~t_nxt[DIV_LOG - 1 + ref_n_r];
      if (t_nxt[DIV_LOG-1:0] == '0) begin
        link.data <= tx_data_i;
      end
    end
  end
endmodule

// File: bench/mcs_link_chk.sv
// assertions on the register and framing link between host end and device end
`timescale 1ns/1ps
module mcs_link_chk
  import mcs_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rst_i,
  input wire logic word_align,
  input wire logic reg_req,
  input wire logic reg_we,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_ack
);
  logic seen_r;
  logic rd_pend_r;
  logic [7:0] last_stat_r;
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // remembers whether any request went out since reset
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      seen_r <= 1'b0;
    end else if (reg_req) begin
      seen_r <= 1'b1;
    end
  end
  // last status byte read back; the alignment strobe must follow a good one
  always_ff @(posedge sys_clk_i or posedge rst_i) begin
    if (rst_i) begin
      rd_pend_r <= 1'b0;
      last_stat_r <= 8'h00;
    end else begin
      rd_pend_r <= reg_req && !reg_we && reg_addr == SYNC_STAT_OFS;
      if (reg_ack && rd_pend_r) begin
        last_stat_r <= reg_rdata;
      end
    end
  end
  sequence s_req;
    reg_req;
  endsequence
  sequence s_ack;
    ##1 reg_ack;
  endsequence
  property p_answer;
    s_req |-> s_ack;
  endproperty
  ack_follows_req_a: assert property (p_answer)
    else $error("register request not answered in the next cycle");
  ack_has_cause_a: assert property (reg_ack |-> $past(reg_req))
    else $error("register answer without a request");
  req_single_a: assert property (reg_req |=> !reg_req)
    else $error("register request longer than one cycle");
  ctrl_value_a: assert property (reg_req && reg_we |-> reg_addr == SYNC_CTRL_OFS &&
    (reg_wdata == CTRL_DATA_RATE || reg_wdata == CTRL_FIFO_RATE))
    else $error("unexpected register write");
  first_write_a: assert property (reg_req && !seen_r |-> reg_we && reg_addr == SYNC_CTRL_OFS)
    else $error("first request is not the sync control write");
  frame_len_a: assert property ($rose(word_align) |-> word_align [*4])
    else $error("word align shorter than two words");
  lock_first_a: assert property ($rose(word_align) |->
    last_stat_r[STAT_LOCK_BIT] && !last_stat_r[STAT_LOST_BIT])
    else $error("word align without a locked status read");
  rdata_hold_a: assert property (!reg_req |=> $stable(reg_rdata))
    else $error("read data changed without a request");
endmodule

// File: bench/tb.sv
// self-checking bench: host end and device end joined over the link
`timescale 1ns/1ps
module tb;
  import mcs_pkg::*;
  logic clk, rst, psel, penable, pwrite, pll_mode, pready, pslverr, irq, locked;
  logic [7:0] paddr;
  logic [7:0] last_ctrl;
  logic [31:0] pwdata, prdata, q;
  logic [15:0] tx_data, dac_data;
  logic [5:0] phase;
  logic e;
  int error_cnt, samples_checked;
  mcs_link_if mcs_link_if_i ();
  mcs_sync_dev #(.DIV(2)) mcs_sync_dev_i (.sys_clk_i(clk), .rst_i(rst), .link(mcs_link_if_i),
    .pll_mode_i(pll_mode), .dac_data_o(dac_data), .clk_phase_o(phase), .locked_o(locked));
  mcs_sync_host #(.DIV(2), .DIV_LOG(1)) mcs_sync_host_i (.sys_clk_i(clk), .rst_i(rst),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_data_i(tx_data), .irq_o(irq),
    .link(mcs_link_if_i));
  mcs_link_chk mcs_link_chk_i (.sys_clk_i(clk), .rst_i(rst),
    .word_align(mcs_link_if_i.word_align), .reg_req(mcs_link_if_i.reg_req),
    .reg_we(mcs_link_if_i.reg_we), .reg_addr(mcs_link_if_i.reg_addr),
    .reg_wdata(mcs_link_if_i.reg_wdata), .reg_rdata(mcs_link_if_i.reg_rdata),
    .reg_ack(mcs_link_if_i.reg_ack));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // last value the host put into the device control register
  always @(posedge clk) begin
    if (mcs_link_if_i.reg_req && mcs_link_if_i.reg_we) begin
      last_ctrl <= mcs_link_if_i.reg_wdata;
    end
  end
  task automatic final_report();
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one apb transfer; entered just after a rising edge, leaves one idle edge behind
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (k >= 50) begin
      error_cnt++;
      final_report();
    end
    @(posedge clk);
  endtask
  task automatic do_reset();
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
  endtask
  // reset values of the host status and interrupt registers and an unmapped access
  task automatic t_regs();
    apb(1'b0, HOST_IRQ_STAT_OFS, 32'h0);
    check("irq_stat_rst", q, 32'h0);
    apb(1'b0, HOST_IRQ_MASK_OFS, 32'h0);
    check("irq_mask_rst", q, 32'h0);
    apb(1'b0, HOST_STAT_OFS, 32'h0);
    check("status_rst", q, 32'h0);
    apb(1'b1, 8'h20, 32'hFFFF_FFFF);
    check("unmapped_err", e, 1'b1);
    check("irq_idle", irq, 1'b0);
  endtask
  // full sequence: configure, poll lock, align, then data and interrupt handling
  task automatic t_sync(input logic fifo, input int n, input logic pll, input logic [15:0] d);
    int k;
    logic r0;
    pll_mode <= pll;
    tx_data <= d;
    do_reset();
    // ref divider in bits 4:2, fifo select in bit 1, start in bit 0
    apb(1'b1, HOST_CTRL_OFS, {27'h0, 3'(n), fifo, 1'b1});
    k = 0;
    do begin
      apb(1'b0, HOST_IRQ_STAT_OFS, 32'h0);
      k++;
    end while (q[IRQ_DONE_BIT] !== 1'b1 && k < 2000);
    if (k >= 2000) begin
      error_cnt++;
      final_report();
    end
    check("ctrl_code", last_ctrl, (fifo || n >= 3) ? CTRL_FIFO_RATE : CTRL_DATA_RATE);
    check("irq_masked", irq, 1'b0);
    apb(1'b0, HOST_STAT_OFS, 32'h0);
    check("status_lock", {q[15:8] & 8'hC0, 7'h0, q[0]}, 16'h4000);
    check("locked", locked, 1'b1);
    check("align_low", mcs_link_if_i.word_align, 1'b0);
    repeat (40) @(posedge clk);
    check("fifo_out", dac_data, d);
    // next reference rise must land on a period boundary of the phase counter
    k = 0;
    do begin
      r0 = mcs_link_if_i.sync_reference_clock;
      @(posedge clk);
      k++;
    end while (!(mcs_link_if_i.sync_reference_clock && !r0) && k < 300);
    if (k >= 300) begin
      error_cnt++;
      final_report();
    end
    check("phase_aligned", phase & ((!pll && (fifo || n >= 3)) ? 6'(2 * FIFO_DEPTH - 1) : 6'h01),
      6'h00);
    apb(1'b1, HOST_IRQ_MASK_OFS, 32'h1);
    check("irq_raised", irq, 1'b1);
    apb(1'b1, HOST_IRQ_STAT_OFS, 32'h1);
    check("irq_cleared", irq, 1'b0);
  endtask
  initial begin
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    pll_mode = 1'b0;
    tx_data = 16'h0000;
    error_cnt = 0;
    samples_checked = 0;
    do_reset();
    t_regs();
    t_sync(1'b0, 0, 1'b0, 16'h1234);
    t_sync(1'b1, 4, 1'b0, 16'hBEEF);
    t_sync(1'b0, 3, 1'b0, 16'h0F0F);
    t_sync(1'b1, 0, 1'b1, 16'hC3A5);
    t_sync(1'b0, 2, 1'b1, 16'h5A96);
    final_report();
  end
  // cuts a hang short
  initial begin
    #900000;
    error_cnt++;
    final_report();
  end
endmodule
